/* serial_if_regs.sv */
// Purpose: Status, control and data registers of an asynchronous serial interface
// Assumes: Single 200 MHz clock; rxd pin is asynchronous and synchronised here
// Notes:   Fixed bit rate; LIN header features are not present
//
// What this block does
// - Holding-empty sets on load into shifter; cleared by status access then data write.
// - Status reads C0h after reset: holding-empty and done set.
// - Done sets after a data character, never after preamble or break.
// - Rx full sets on transfer into data register; cleared by status then data read.
// - Idle sets on idle line, rearms only after rx full; cleared by read sequence.
// - Overrun when new word ready while rx full; old data kept.
// - Noise flag sets on noisy character; cleared by status then data read.
// - Framing flag on bad stop bit or break; cleared by read sequence.
// - Framing plus overrun together set only overrun.
// - Parity error sets when enabled; interrupts with its enable; status access then data read or data write clears.
// - Ninth bit is captured and sent from control bits when word length is nine.
// - Disable stops transmitter and receiver at end of current byte.
// - Word length selects eight or nine data bits between start and stop.
// - Wake method picks idle line or address mark for muted receiver.
// - Parity enable generates and checks; odd select latched per byte.
// - Shared interrupt from each flag except noise and framing, paired with its enable.
// - Enable delays start one bit; enable rise during a frame sends one idle preamble after that frame.
// - Receiver hunts for start bit only while enabled.
// - Mute cleared on wake-up; mute writes ignored in address mode while rx full.
// - Break control set then cleared sends one break word after current word.
// - Data write loads transmit holding, data read returns receive holding.
// - With parity enabled the data most significant bit is replaced by parity.
// - Idle-line wake-up clears mute without setting idle.
module serial_if_regs (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line
  input  wire logic        rxd,
  output logic             txd,
  // Shared interrupt
  output logic             irq
);

  serial_if_pkg::frame_control_s    fc_ff;
  serial_if_pkg::transfer_control_s tc_ff;
  logic [7:0] st_ff;
  logic [7:0] tx_hold_ff, rx_hold_ff;
  logic       tx_hold_full_ff;
  logic       arm_ff;
  logic       rxd_s1_ff, rxd_s2_ff;

  // APB decode; zero wait state, pready held high
  logic acc, wr, rd, hit;
  assign acc = psel & penable;
  assign wr  = acc & pwrite;
  assign rd  = acc & ~pwrite;
  assign hit = (paddr == serial_if_pkg::LINE_STATUS_OFS) |
               (paddr == serial_if_pkg::FRAME_CONTROL_OFS) |
               (paddr == serial_if_pkg::TRANSFER_CONTROL_OFS) |
               (paddr == serial_if_pkg::CHAR_DATA_OFS);
  logic st_acc, dat_wr, dat_rd;
  assign st_acc = acc & (paddr == serial_if_pkg::LINE_STATUS_OFS);
  assign dat_wr = wr & (paddr == serial_if_pkg::CHAR_DATA_OFS);
  assign dat_rd = rd & (paddr == serial_if_pkg::CHAR_DATA_OFS);
  logic clr_wr, clr_rd;
  assign clr_wr = arm_ff & dat_wr;
  assign clr_rd = arm_ff & dat_rd;

  // Clear sequence arming: a status access arms, any data access consumes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_ff <= 1'b0;
    end else if (st_acc) begin
      arm_ff <= 1'b1;
    end else if (dat_wr | dat_rd) begin
      arm_ff <= 1'b0;
    end
  end

  // APB outputs registered; unmapped reads give zero with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b1;
      pslverr <= psel & ~penable & ~hit;
      if (psel & ~penable & ~pwrite) begin
        unique case (paddr)
          serial_if_pkg::LINE_STATUS_OFS:      prdata <= {24'h00_0000, st_ff};
          serial_if_pkg::FRAME_CONTROL_OFS:    prdata <= {24'h00_0000, fc_ff};
          serial_if_pkg::TRANSFER_CONTROL_OFS: prdata <= {24'h00_0000, tc_ff};
          serial_if_pkg::CHAR_DATA_OFS:        prdata <= {24'h00_0000, rx_hold_ff};
          default:                             prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_s1_ff <= 1'b1;
      rxd_s2_ff <= 1'b1;
    end else begin
      rxd_s1_ff <= rxd;
      rxd_s2_ff <= rxd_s1_ff;
    end
  end

  // Bit-rate enable: one pulse per bit period; held high with the counter at zero when disabled and idle
  logic [11:0] baud_cnt_ff;
  logic        bit_tick, tx_busy, rx_busy;
  assign bit_tick = (baud_cnt_ff == 12'h000);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt_ff <= 12'h000;
    end else if (fc_ff.serial_disable & ~tx_busy) begin
      baud_cnt_ff <= 12'h000;
    end else if (bit_tick) begin
      baud_cnt_ff <= serial_if_pkg::BIT_CYCLES - 12'h001;
    end else begin
      baud_cnt_ff <= baud_cnt_ff - 12'h001;
    end
  end

  // Transmitter
  serial_if_pkg::tx_state_e tx_st_ff;
  logic [9:0] tx_sh_ff;
  logic [3:0] tx_cnt_ff;
  logic       tx_data_ff, tx_brk_ff, tx_pre_ff;
  logic       brk_pend_ff, pre_pend_ff, ena_wait_ff;
  logic       tx_start, tx_end;
  assign tx_busy  = (tx_st_ff != serial_if_pkg::TX_IDLE);
  assign tx_end   = (tx_st_ff == serial_if_pkg::TX_STOP) & bit_tick;
  assign tx_start = (tx_st_ff == serial_if_pkg::TX_IDLE) & bit_tick & tc_ff.tx_enable &
                    ~ena_wait_ff & ~fc_ff.serial_disable &
                    (pre_pend_ff | brk_pend_ff | tx_hold_full_ff);

  // Parity over 7 or 8 low bits, sent in place of the top data bit
  logic       par_bit;
  logic [8:0] tx_word;
  always_comb begin
    par_bit = fc_ff.word_len_sel ? ^tx_hold_ff[7:0] : ^tx_hold_ff[6:0];
    par_bit = par_bit ^ fc_ff.parity_odd_sel;
    tx_word = {fc_ff.tx_ninth_bit, tx_hold_ff};
    if (fc_ff.parity_enable) begin
      if (fc_ff.word_len_sel) tx_word[8] = par_bit;
      else tx_word[7] = par_bit;
    end
  end

  // Break and preamble requests from control bit edges
  logic sbk_fall, te_rise;
  assign sbk_fall = wr & (paddr == serial_if_pkg::TRANSFER_CONTROL_OFS) &
                    tc_ff.send_break_ctl & ~pwdata[0];
  assign te_rise  = wr & (paddr == serial_if_pkg::TRANSFER_CONTROL_OFS) &
                    ~tc_ff.tx_enable & pwdata[3];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_pend_ff <= 1'b0;
      pre_pend_ff <= 1'b0;
      ena_wait_ff <= 1'b0;
    end else begin
      if (sbk_fall) brk_pend_ff <= 1'b1;
      else if (tx_start & ~pre_pend_ff) brk_pend_ff <= 1'b0;
      if (te_rise & tx_busy) pre_pend_ff <= 1'b1;
      else if (tx_start) pre_pend_ff <= 1'b0;
      if (te_rise) ena_wait_ff <= 1'b1;
      else if (bit_tick) ena_wait_ff <= 1'b0;
    end
  end

  // Transmit shifter: LSB first, start 0, data, stop 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_ff   <= serial_if_pkg::TX_IDLE;
      tx_sh_ff   <= 10'h3FF;
      tx_cnt_ff  <= 4'h0;
      tx_data_ff <= 1'b0;
      tx_brk_ff  <= 1'b0;
      tx_pre_ff  <= 1'b0;
      txd        <= 1'b1;
    end else if (bit_tick) begin
      unique case (tx_st_ff)
        serial_if_pkg::TX_IDLE: begin
          txd <= 1'b1;
          if (tx_start) begin
            tx_pre_ff  <= pre_pend_ff;
            tx_brk_ff  <= brk_pend_ff & ~pre_pend_ff;
            tx_data_ff <= ~pre_pend_ff & ~brk_pend_ff;
            tx_sh_ff   <= {1'b0, tx_word};
            tx_st_ff   <= serial_if_pkg::TX_START;
          end
        end
        serial_if_pkg::TX_START: begin
          txd       <= ~tx_pre_ff & 1'b0 | tx_pre_ff;
          tx_cnt_ff <= fc_ff.word_len_sel ? 4'h9 : 4'h8;
          tx_st_ff  <= serial_if_pkg::TX_DATA;
        end
        serial_if_pkg::TX_DATA: begin
          txd       <= tx_pre_ff | (~tx_brk_ff & tx_sh_ff[0]);
          tx_sh_ff  <= {1'b1, tx_sh_ff[9:1]};
          tx_cnt_ff <= tx_cnt_ff - 4'h1;
          if (tx_cnt_ff == 4'h1) tx_st_ff <= serial_if_pkg::TX_STOP;
        end
        serial_if_pkg::TX_STOP: begin
          txd      <= ~tx_brk_ff; // Break holds the line low through the stop slot
          tx_st_ff <= serial_if_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Receiver: sample at mid bit using a half-bit offset counter
  serial_if_pkg::rx_state_e rx_st_ff;
  logic [11:0] rx_tmr_ff;
  logic [3:0]  rx_cnt_ff;
  logic [8:0]  rx_sh_ff;
  logic        rx_noise_ff, rxd_prev_ff;
  logic        rx_done, rx_samp;
  logic [11:0] idle_cnt_ff;
  logic [3:0]  idle_bits_ff;
  logic        idle_armed_ff;
  assign rx_samp = (rx_tmr_ff == 12'h000);
  assign rx_busy = (rx_st_ff != serial_if_pkg::RX_HUNT);
  assign rx_done = (rx_st_ff == serial_if_pkg::RX_STOP) & rx_samp;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_ff    <= serial_if_pkg::RX_HUNT;
      rx_tmr_ff   <= 12'h000;
      rx_cnt_ff   <= 4'h0;
      rx_sh_ff    <= 9'h000;
      rx_noise_ff <= 1'b0;
      rxd_prev_ff <= 1'b1;
    end else begin
      rxd_prev_ff <= rxd_s2_ff;
      rx_tmr_ff   <= rx_samp ? serial_if_pkg::BIT_CYCLES - 12'h001 : rx_tmr_ff - 12'h001;
      unique case (rx_st_ff)
        serial_if_pkg::RX_HUNT: begin
          if (tc_ff.rx_enable & ~fc_ff.serial_disable & ~rxd_s2_ff) begin
            rx_tmr_ff   <= serial_if_pkg::HALF_CYCLES;
            rx_noise_ff <= 1'b0;
            rx_st_ff    <= serial_if_pkg::RX_START;
          end
        end
        serial_if_pkg::RX_START: if (rx_samp) begin
          rx_cnt_ff <= fc_ff.word_len_sel ? 4'h9 : 4'h8;
          rx_st_ff  <= rxd_s2_ff ? serial_if_pkg::RX_HUNT : serial_if_pkg::RX_DATA;
        end
        serial_if_pkg::RX_DATA: if (rx_samp) begin
          rx_sh_ff  <= fc_ff.word_len_sel ? {rxd_s2_ff, rx_sh_ff[8:1]}
                                          : {1'b0, rxd_s2_ff, rx_sh_ff[7:1]};
          rx_cnt_ff <= rx_cnt_ff - 4'h1;
          if (rx_cnt_ff == 4'h1) rx_st_ff <= serial_if_pkg::RX_STOP;
        end else if (rxd_s2_ff != rxd_prev_ff && rx_tmr_ff < 12'h010) begin
          rx_noise_ff <= 1'b1; // Edge near the sample point counts as noise
        end
        serial_if_pkg::RX_STOP: if (rx_samp) rx_st_ff <= serial_if_pkg::RX_HUNT;
      endcase
    end
  end

  // Received word properties at the stop sample
  logic rx_fe, rx_pe, rx_msb, rx_addr;
  assign rx_fe   = ~rxd_s2_ff;
  assign rx_msb  = fc_ff.word_len_sel ? rx_sh_ff[8] : rx_sh_ff[7];
  assign rx_pe   = fc_ff.parity_enable & ((fc_ff.word_len_sel ? ^rx_sh_ff : ^rx_sh_ff[7:0])
                   ^ fc_ff.parity_odd_sel);
  assign rx_addr = fc_ff.wake_method & rx_msb;

  // Idle line: nine bit times (ten for nine-bit words) of high line while receiver idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_ff  <= 12'h000;
      idle_bits_ff <= 4'h0;
    end else if (rx_busy | ~rxd_s2_ff | ~tc_ff.rx_enable) begin
      idle_cnt_ff  <= 12'h000;
      idle_bits_ff <= 4'h0;
    end else if (idle_cnt_ff == serial_if_pkg::BIT_CYCLES - 12'h001) begin
      idle_cnt_ff <= 12'h000;
      if (idle_bits_ff != serial_if_pkg::BREAK_BITS + 4'h1) idle_bits_ff <= idle_bits_ff + 4'h1;
    end else begin
      idle_cnt_ff <= idle_cnt_ff + 12'h001;
    end
  end
  logic idle_seen;
  assign idle_seen = (idle_cnt_ff == serial_if_pkg::BIT_CYCLES - 12'h001) &
                     (idle_bits_ff == (fc_ff.word_len_sel ? 4'h9 : 4'h8));

  // Control registers and ninth-bit capture
  logic rx_take, rx_over, mute_wake_idle, mute_wake_addr;
  assign rx_take        = rx_done & (~tc_ff.rx_mute | rx_addr);
  assign rx_over        = rx_take & st_ff[serial_if_pkg::ST_RXF];
  assign mute_wake_idle = tc_ff.rx_mute & ~fc_ff.wake_method & idle_seen;
  assign mute_wake_addr = tc_ff.rx_mute & rx_done & rx_addr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fc_ff <= serial_if_pkg::FRAME_CONTROL_RST;
      tc_ff <= serial_if_pkg::TRANSFER_CONTROL_RST;
    end else begin
      if (wr & (paddr == serial_if_pkg::FRAME_CONTROL_OFS)) fc_ff[6:0] <= pwdata[6:0];
      if (rx_take & ~rx_over & fc_ff.word_len_sel) fc_ff.rx_ninth_bit <= rx_sh_ff[8];
      if (wr & (paddr == serial_if_pkg::TRANSFER_CONTROL_OFS)) begin
        tc_ff[7:2] <= pwdata[7:2];
        tc_ff[0]   <= pwdata[0];
        if (~(fc_ff.wake_method & st_ff[serial_if_pkg::ST_RXF])) tc_ff.rx_mute <= pwdata[1];
      end
      if (mute_wake_idle | mute_wake_addr) tc_ff.rx_mute <= 1'b0;
    end
  end

  // Transmit holding register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold_ff      <= 8'h00;
      tx_hold_full_ff <= 1'b0;
    end else if (dat_wr) begin
      tx_hold_ff      <= pwdata[7:0];
      tx_hold_full_ff <= 1'b1;
    end else if (tx_start & tx_hold_full_ff & ~pre_pend_ff & ~brk_pend_ff) begin
      tx_hold_full_ff <= 1'b0;
    end
  end

  // Receive holding register keeps old contents on overrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_hold_ff <= 8'h00;
    end else if (rx_take & ~rx_over) begin
      rx_hold_ff <= rx_sh_ff[7:0];
    end
  end

  // Status flags; a set in the same cycle as a clear wins
  logic tx_load;
  assign tx_load = tx_start & tx_hold_full_ff & ~pre_pend_ff & ~brk_pend_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff         <= serial_if_pkg::LINE_STATUS_RST;
      idle_armed_ff <= 1'b1;
    end else begin
      if (tx_load) st_ff[serial_if_pkg::ST_TXE] <= 1'b1;
      else if (clr_wr) st_ff[serial_if_pkg::ST_TXE] <= 1'b0;
      if (tx_end & tx_data_ff) st_ff[serial_if_pkg::ST_TC] <= 1'b1;
      else if (clr_wr) st_ff[serial_if_pkg::ST_TC] <= 1'b0;
      if (rx_take & ~rx_over) st_ff[serial_if_pkg::ST_RXF] <= 1'b1;
      else if (clr_rd) st_ff[serial_if_pkg::ST_RXF] <= 1'b0;
      if (rx_over) st_ff[serial_if_pkg::ST_OVR] <= 1'b1;
      else if (clr_rd) st_ff[serial_if_pkg::ST_OVR] <= 1'b0;
      if (rx_take & ~rx_over & rx_noise_ff) st_ff[serial_if_pkg::ST_NF] <= 1'b1;
      else if (clr_rd) st_ff[serial_if_pkg::ST_NF] <= 1'b0;
      if (rx_take & ~rx_over & rx_fe) st_ff[serial_if_pkg::ST_FE] <= 1'b1;
      else if (clr_rd) st_ff[serial_if_pkg::ST_FE] <= 1'b0;
      if (rx_take & ~rx_over & rx_pe) st_ff[serial_if_pkg::ST_PE] <= 1'b1;
      else if (arm_ff & (dat_rd | dat_wr)) st_ff[serial_if_pkg::ST_PE] <= 1'b0;
      // Idle rearms only after a new character has been taken
      if (idle_seen & idle_armed_ff & ~tc_ff.rx_mute) begin
        st_ff[serial_if_pkg::ST_IDLE] <= 1'b1;
        idle_armed_ff <= 1'b0;
      end else begin
        if (clr_rd) st_ff[serial_if_pkg::ST_IDLE] <= 1'b0;
        if (rx_take & ~rx_over) idle_armed_ff <= 1'b1;
      end
    end
  end

  // Shared interrupt request, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (st_ff[serial_if_pkg::ST_TXE] & tc_ff.tx_empty_int_en) |
             (st_ff[serial_if_pkg::ST_TC] & tc_ff.tx_done_int_en) |
             ((st_ff[serial_if_pkg::ST_OVR] | st_ff[serial_if_pkg::ST_RXF]) & tc_ff.rx_int_en) |
             (st_ff[serial_if_pkg::ST_IDLE] & tc_ff.idle_int_en) |
             (st_ff[serial_if_pkg::ST_PE] & fc_ff.parity_int_en);
    end
  end

endmodule

/* serial_if_pkg.sv */
// Purpose: Shared constants and carrier types for the serial interface register block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Bit rate is a fixed divider; baud registers are outside this block
package serial_if_pkg;

  // Register byte offsets
  localparam logic [7:0] LINE_STATUS_OFS      = 8'h00;
  localparam logic [7:0] FRAME_CONTROL_OFS    = 8'h04;
  localparam logic [7:0] TRANSFER_CONTROL_OFS = 8'h08;
  localparam logic [7:0] CHAR_DATA_OFS        = 8'h0C;

  // Reset values
  localparam logic [7:0] LINE_STATUS_RST      = 8'hC0;
  localparam logic [7:0] FRAME_CONTROL_RST    = 8'h00;
  localparam logic [7:0] TRANSFER_CONTROL_RST = 8'h00;

  // Status bit positions
  localparam int ST_TXE  = 7;
  localparam int ST_TC   = 6;
  localparam int ST_RXF  = 5;
  localparam int ST_IDLE = 4;
  localparam int ST_OVR  = 3;
  localparam int ST_NF   = 2;
  localparam int ST_FE   = 1;
  localparam int ST_PE   = 0;

  // Bit timing: clocks per bit and receive sample point
  localparam int          CLK_HZ        = 200_000_000;
  localparam int          BAUD          = 115_200;
  localparam logic [11:0] BIT_CYCLES    = 12'(CLK_HZ / BAUD);
  localparam logic [11:0] HALF_CYCLES   = 12'(CLK_HZ / BAUD / 2);
  localparam logic [3:0]  BREAK_BITS    = 4'h9;

  // Frame controls
  typedef struct packed {
    logic rx_ninth_bit;
    logic tx_ninth_bit;
    logic serial_disable;
    logic word_len_sel;
    logic wake_method;
    logic parity_enable;
    logic parity_odd_sel;
    logic parity_int_en;
  } frame_control_s;

  typedef struct packed {
    logic tx_empty_int_en;
    logic tx_done_int_en;
    logic rx_int_en;
    logic idle_int_en;
    logic tx_enable;
    logic rx_enable;
    logic rx_mute;
    logic send_break_ctl;
  } transfer_control_s;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA  = 4'b0100,
    TX_STOP  = 4'b1000
  } tx_state_e;

  typedef enum logic [3:0] {
    RX_HUNT  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_e;

endpackage

/* serial_if_regs_asserts.sv */
// Purpose: Port-level checks for the serial register block
// Assumes: Zero-wait APB slave, offsets from the package
// Notes:   Shadows of control writes let readback and irq be judged
module serial_if_regs_asserts (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Line and interrupt
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        irq
);
  localparam int ONE_BIT = int'(serial_if_pkg::BIT_CYCLES);
  localparam int QUIET   = 11 * ONE_BIT;
  logic [14:0] quiet_ff;
  logic [7:0]  ctl_ff;
  logic [6:0]  frm_ff;
  logic [11:0] te_age_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence access_s;
    psel && penable;
  endsequence
  sequence start_low_s;
    !txd [*8];
  endsequence

  // Shadow control writes as the slave takes them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= 8'h00;
      frm_ff <= 7'h00;
    end else if (psel && penable && pwrite) begin
      if (paddr == serial_if_pkg::TRANSFER_CONTROL_OFS) ctl_ff <= pwdata[7:0];
      if (paddr == serial_if_pkg::FRAME_CONTROL_OFS) frm_ff <= pwdata[6:0];
    end
  end

  // Time the line has rested high; a frame never rests that long mid-word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_ff <= 15'h7FFF;
    else if (!txd) quiet_ff <= 15'h0000;
    else if (quiet_ff != 15'h7FFF) quiet_ff <= quiet_ff + 15'h0001;
  end

  // Age of the transmitter enable; only a rise on a quiet line is timed,
  // since a pulse during a frame lets the current word go out at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) te_age_ff <= 12'h000;
    else if (psel && penable && pwrite && pwdata[3] && !ctl_ff[3] &&
             paddr == serial_if_pkg::TRANSFER_CONTROL_OFS &&
             quiet_ff >= QUIET) te_age_ff <= 12'h000;
    else if (te_age_ff != 12'hFFF) te_age_ff <= te_age_ff + 12'h001;
  end

  access_ready_a: assert property (access_s |-> pready)
    else $error("pready low in access phase");
  unmapped_err_a: assert property (access_s ##0 (paddr > 8'h0C) |-> pslverr)
    else $error("no error on unmapped access");
  mapped_ok_a: assert property (access_s ##0 (paddr <= 8'h0C && paddr[1:0] == 2'b00)
    |-> !pslverr) else $error("error on mapped access");
  upper_zero_a: assert property (access_s ##0 !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  ctl_back_a: assert property (access_s ##0 (!pwrite && paddr == 8'h08) |->
    prdata[7:2] == ctl_ff[7:2] && prdata[0] == ctl_ff[0])
    else $error("transfer_control readback differs");
  frm_back_a: assert property (access_s ##0 (!pwrite && paddr == 8'h04) |->
    prdata[6:0] == frm_ff) else $error("frame_control readback differs");
  irq_masked_a: assert property ((ctl_ff[7:4] == 4'h0 && !frm_ff[0] &&
    $past(ctl_ff[7:4]) == 4'h0 && !$past(frm_ff[0])) |-> !irq)
    else $error("irq with every enable clear");
  start_hold_a: assert property ($fell(txd) |-> start_low_s)
    else $error("start bit too short");
  tx_delay_a: assert property ((ctl_ff[3] && te_age_ff < ONE_BIT) |-> txd)
    else $error("transmission began within one bit of enable");
endmodule

bind serial_if_regs serial_if_regs_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));

/* serial_node.sv */
// Purpose: Remote serial node facing the block's line pins
// Assumes: 8N1 frames at the package bit rate
// Notes:   Line rests high between frames, as with a pull-up
module serial_node (
  // Line
  input  wire logic       pclk,
  input  wire logic       txd,
  output logic            rxd,
  // Last character taken from the block
  output logic      [7:0] got
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BIT = int'(serial_if_pkg::BIT_CYCLES);
  logic sending;

  initial begin
    rxd = 1'b1;
    got = 8'h00;
    sending = 1'b0;
  end

  // Start low, data least significant first, stop high
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    // A new frame waits for the full stop bit of the one before
    while (sending) @(posedge pclk);
    sending = 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      rxd <= fr[i];
      repeat (BIT - 1) @(posedge pclk);
    end
    sending = 1'b0;
  endtask

  // Sample at mid bit so edge jitter does not matter
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge pclk);
      got[i] = txd;
    end
    repeat (BIT) @(posedge pclk);
  end
endmodule

/* uart_status_control_regs_test.sv */
// Purpose: Register, interrupt and line tests of the serial block
// Assumes: Zero-wait APB slave, 8N1 remote node
// Notes:   Full bit rate, so few frames fit in the run
module uart_status_control_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 99000;
  localparam logic [7:0] ST = serial_if_pkg::LINE_STATUS_OFS;
  localparam logic [7:0] FRM = serial_if_pkg::FRAME_CONTROL_OFS;
  localparam logic [7:0] CTL = serial_if_pkg::TRANSFER_CONTROL_OFS;
  localparam logic [7:0] DAT = serial_if_pkg::CHAR_DATA_OFS;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, irq, err;
  logic [7:0]  paddr, got_byte;
  logic [31:0] pwdata, prdata, q;
  int          n_errors, cmp_count, cycles;

  serial_if_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
  serial_node node (.pclk(pclk), .txd(txd), .rxd(rxd), .got(got_byte));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read status until a flag shows; each read also arms the clear
  task automatic poll(input int b);
    int k;
    k = 0;
    q = 32'h0000_0000;
    while (q[b] !== 1'b1 && k < 12000) begin
      xfer(1'b0, ST, 32'h0000_0000);
      k++;
    end
    chk("status flag", 32'h0000_0001, {31'd0, q[b]});
  endtask

  // Hang guard: a run past the ceiling counts against it
  always @(posedge pclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      $display("[FAIL] run length expected %0d seen %0d", LIMIT - 1, cycles);
      tally_and_finish();
    end
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, read-only status, unmapped slot
    xfer(1'b0, ST, 32'h0000_0000);
    chk("line_status", 32'h0000_00C0, q);
    xfer(1'b0, CTL, 32'h0000_0000);
    chk("transfer_control", 32'h0000_0000, q);
    xfer(1'b1, ST, 32'h0000_0000);
    xfer(1'b0, ST, 32'h0000_0000);
    chk("line_status after write", 32'h0000_00C0, q);
    xfer(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'd0, err});
    $display("test reset done");
    // Controls read back; word length changed only while idle
    xfer(1'b1, FRM, 32'h0000_007F);
    xfer(1'b0, FRM, 32'h0000_0000);
    chk("frame_control", 32'h0000_007F, q & 32'h0000_007F);
    xfer(1'b1, FRM, 32'h0000_0000);
    xfer(1'b1, CTL, 32'h0000_0080);
    repeat (2) @(posedge pclk);
    chk("irq holding empty", 32'h0000_0001, {31'd0, irq});
    xfer(1'b1, CTL, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk("irq masked", 32'h0000_0000, {31'd0, irq});
    $display("test controls done");
    // Full duplex: send A5 while the node sends 3C
    xfer(1'b1, CTL, 32'h0000_000C);
    fork
      node.send(8'h3C);
    join_none
    xfer(1'b0, ST, 32'h0000_0000);
    xfer(1'b1, DAT, 32'h0000_00A5);
    xfer(1'b0, ST, 32'h0000_0000);
    chk("empty and done cleared", 32'h0000_0000, {30'd0, q[7:6]});
    poll(6);
    chk("holding empty again", 32'h0000_0001, {31'd0, q[7]});
    chk("sent char", 32'h0000_00A5, {24'd0, got_byte});
    poll(5);
    $display("test duplex done");
    // Second word while full: overrun keeps the old word
    fork
      node.send(8'h22);
    join_none
    poll(3);
    xfer(1'b0, DAT, 32'h0000_0000);
    chk("kept char", 32'h0000_003C, q);
    xfer(1'b0, ST, 32'h0000_0000);
    chk("full, overrun, framing", 32'h0000_0000, {29'd0, q[5], q[3], q[1]});
    poll(4);
    $display("test overrun and idle done");
    // Mute after a byte was taken; a muted char is dropped, idle wakes
    xfer(1'b0, DAT, 32'h0000_0000);
    xfer(1'b1, CTL, 32'h0000_000E);
    xfer(1'b0, CTL, 32'h0000_0000);
    chk("transfer_control mute", 32'h0000_000E, q);
    node.send(8'h5A);
    repeat (10 * int'(serial_if_pkg::BIT_CYCLES)) @(posedge pclk);
    xfer(1'b0, CTL, 32'h0000_0000);
    chk("mute woken", 32'h0000_000C, q);
    xfer(1'b0, ST, 32'h0000_0000);
    chk("muted full, idle", 32'h0000_0000, {30'd0, q[5], q[4]});
    $display("test mute done");
    tally_and_finish();
  end
endmodule
